/* verilog/tws_pkg.sv */
// constants and types for the two-wire command slave
package tws_pkg;
  localparam logic [6:0] OWN_ADDR       = 7'h60;
  localparam logic [2:0] BIT_FIRST      = 3'h0;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BIT_STEP       = 3'h1;
  localparam logic [7:0] BYTE_NONE      = 8'h00;
  localparam int         CLK_KHZ        = 10000;
  localparam int         SCL_MAX_KHZ    = 100;
  localparam int         SCL_MIN_CYC    = (CLK_KHZ + SCL_MAX_KHZ - 1) / SCL_MAX_KHZ;
  localparam int         STRETCH_TYP_US = 100;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_WBYTE, ST_ACKS, ST_STR, ST_ACK, ST_RBYTE, ST_RACK, ST_RNEXT, ST_IGN
  } tws_state_t;

  typedef enum logic [2:0] {
    EV_ADDR_WR, EV_ADDR_RD, EV_CMD, EV_DATA, EV_RD_NEXT, EV_STOP
  } tws_ev_kind_t;

  typedef struct packed {
    tws_ev_kind_t kind;
    logic [7:0]   data;
  } tws_ev_t;
endpackage

/* verilog/tws_slave.sv */
// two-wire command slave with clock stretching toward the module processor
// Overview of operation
// - only the fixed seven-bit address 60h is answered, standard seven-bit addressing.
// - clock and data lines are only ever pulled low, released otherwise.
// - after addressing and after each host byte the clock is held low until the processor is ready.
// - every command is one eight-bit byte, optionally followed by operands or results.
// - read or write of a parameter is chosen by the address direction bit.
// - a matching address is acknowledged on the next clock, then the command byte too.
// - in a write every further data byte is acknowledged until stop.
`timescale 1ns/10ps
module tws_slave (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  output tws_pkg::tws_ev_t      ev,
  output logic                  ev_valid,
  input  wire logic             proc_rdy,
  input  wire logic [7:0]       tx_byte
);

  logic                scl_m_q, scl_s_q, scl_p_q;
  logic                sda_m_q, sda_s_q, sda_p_q;
  logic                scl_rise, scl_fall, bus_start, bus_stop;
  tws_pkg::tws_state_t st_q;
  tws_pkg::tws_ev_kind_t kind_q;
  tws_pkg::tws_ev_t    ev_q;
  logic                ev_valid_q;
  logic [2:0]          cnt_q;
  logic [7:0]          sr_q;
  logic [7:0]          tx_q;
  logic                rd_q, first_q, cont_q;
  logic                scl_oe_q, sda_oe_q, scl_o_q, sda_o_q;
  logic                addr_end, addr_hit;

  // two-stage synchronisers and previous sample
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_m_q <= 1'h1;
      scl_s_q <= 1'h1;
      scl_p_q <= 1'h1;
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign addr_end  = (st_q == tws_pkg::ST_ADDR) & scl_rise & (cnt_q == tws_pkg::BIT_LAST);
  assign addr_hit  = (sr_q[6:0] == tws_pkg::OWN_ADDR);

  // line drive levels are always low
  always_ff @(posedge clk) begin
    scl_o_q <= 1'h0;
    sda_o_q <= 1'h0;
  end

  // protocol engine
  always_ff @(posedge clk) begin
    ev_valid_q <= 1'h0;
    if (sys_rst) begin
      st_q     <= tws_pkg::ST_IDLE;
      kind_q   <= tws_pkg::EV_STOP;
      ev_q     <= '0;
      cnt_q    <= tws_pkg::BIT_FIRST;
      sr_q     <= tws_pkg::BYTE_NONE;
      tx_q     <= tws_pkg::BYTE_NONE;
      rd_q     <= 1'h0;
      first_q  <= 1'h0;
      cont_q   <= 1'h0;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else if (bus_start) begin
      st_q     <= tws_pkg::ST_ADDR;
      cnt_q    <= tws_pkg::BIT_FIRST;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else if (bus_stop) begin
      if (st_q != tws_pkg::ST_IDLE && st_q != tws_pkg::ST_IGN) begin
        ev_valid_q <= 1'h1;
        ev_q.kind  <= tws_pkg::EV_STOP;
        ev_q.data  <= tws_pkg::BYTE_NONE;
      end
      st_q     <= tws_pkg::ST_IDLE;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else begin
      case (st_q)
        tws_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sr_q  <= {sr_q[6:0], sda_s_q};
            cnt_q <= cnt_q + tws_pkg::BIT_STEP;
            if (cnt_q == tws_pkg::BIT_LAST) begin
              if (addr_hit) begin
                rd_q    <= sda_s_q;
                first_q <= ~sda_s_q;
                kind_q  <= sda_s_q ? tws_pkg::EV_ADDR_RD : tws_pkg::EV_ADDR_WR;
                st_q    <= tws_pkg::ST_ACKS;
              end else begin
                st_q <= tws_pkg::ST_IGN;
              end
            end
          end
        end
        tws_pkg::ST_WBYTE: begin
          if (scl_rise) begin
            sr_q  <= {sr_q[6:0], sda_s_q};
            cnt_q <= cnt_q + tws_pkg::BIT_STEP;
            if (cnt_q == tws_pkg::BIT_LAST) begin
              kind_q  <= first_q ? tws_pkg::EV_CMD : tws_pkg::EV_DATA;
              first_q <= 1'h0;
              st_q    <= tws_pkg::ST_ACKS;
            end
          end
        end
        tws_pkg::ST_ACKS: begin
          if (scl_fall) begin
            sda_oe_q   <= 1'h1;
            scl_oe_q   <= 1'h1;
            ev_valid_q <= 1'h1;
            ev_q.kind  <= kind_q;
            ev_q.data  <= sr_q;
            cont_q     <= 1'h0;
            st_q       <= tws_pkg::ST_STR;
          end
        end
        tws_pkg::ST_RNEXT: begin
          if (scl_fall) begin
            scl_oe_q   <= 1'h1;
            ev_valid_q <= 1'h1;
            ev_q.kind  <= tws_pkg::EV_RD_NEXT;
            ev_q.data  <= tws_pkg::BYTE_NONE;
            cont_q     <= 1'h1;
            st_q       <= tws_pkg::ST_STR;
          end
        end
        tws_pkg::ST_STR: begin
          if (proc_rdy) begin
            scl_oe_q <= 1'h0;
            tx_q     <= tx_byte;
            if (cont_q) begin
              sda_oe_q <= ~tx_byte[7];
              cnt_q    <= tws_pkg::BIT_FIRST;
              st_q     <= tws_pkg::ST_RBYTE;
            end else begin
              st_q <= tws_pkg::ST_ACK;
            end
          end
        end
        tws_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_q <= tws_pkg::BIT_FIRST;
            if (rd_q) begin
              sda_oe_q <= ~tx_q[7];
              st_q     <= tws_pkg::ST_RBYTE;
            end else begin
              sda_oe_q <= 1'h0;
              st_q     <= tws_pkg::ST_WBYTE;
            end
          end
        end
        tws_pkg::ST_RBYTE: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + tws_pkg::BIT_STEP;
          end else if (scl_fall) begin
            if (cnt_q == tws_pkg::BIT_FIRST) begin
              sda_oe_q <= 1'h0;
              st_q     <= tws_pkg::ST_RACK;
            end else begin
              sda_oe_q <= ~tx_q[6];
              tx_q     <= {tx_q[6:0], 1'h0};
            end
          end
        end
        tws_pkg::ST_RACK: begin
          if (scl_rise) begin
            st_q <= sda_s_q ? tws_pkg::ST_IGN : tws_pkg::ST_RNEXT;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign scl_o    = scl_o_q;
  assign scl_oe   = scl_oe_q;
  assign sda_o    = sda_o_q;
  assign sda_oe   = sda_oe_q;
  assign ev       = ev_q;
  assign ev_valid = ev_valid_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence seq_addr_hit;
    addr_end && addr_hit && !bus_start && !bus_stop;
  endsequence

  sequence seq_ack_slot;
    (st_q == tws_pkg::ST_ACKS) && scl_fall && !bus_start && !bus_stop;
  endsequence

  chk_low_only: assert property (scl_o == 1'h0 && sda_o == 1'h0)
    else $error("line driven high");
  chk_foreign_addr: assert property (addr_end && !addr_hit && !bus_start && !bus_stop
    |=> st_q == tws_pkg::ST_IGN)
    else $error("foreign address not ignored");
  chk_ignore_quiet: assert property (st_q == tws_pkg::ST_IGN |-> !sda_oe && !scl_oe)
    else $error("drive while ignoring");
  chk_dir_bit: assert property (seq_addr_hit |=> rd_q == $past(sda_s_q)
    && st_q == tws_pkg::ST_ACKS)
    else $error("direction bit not taken");
  chk_ack_stretch: assert property (seq_ack_slot |=> sda_oe && scl_oe && ev_valid)
    else $error("ack or stretch missing");
  chk_stretch_hold: assert property ((st_q == tws_pkg::ST_STR) && !proc_rdy
    && !bus_start && !bus_stop |=> scl_oe)
    else $error("clock released early");
  chk_stretch_free: assert property ((st_q == tws_pkg::ST_STR) && proc_rdy
    && !bus_start && !bus_stop |=> !scl_oe ##1 !scl_oe)
    else $error("clock not released");
  chk_data_ack: assert property (ev_valid && (ev.kind == tws_pkg::EV_DATA
    || ev.kind == tws_pkg::EV_CMD) |-> sda_oe && $past(st_q) == tws_pkg::ST_ACKS)
    else $error("data byte not acknowledged");
  chk_event_pulse: assert property (ev_valid |=> !ev_valid)
    else $error("event longer than one cycle");

endmodule

/* testbench/tws_host_model.sv */
// two-wire bus master model for the command slave bench
`timescale 1ns/10ps
module tws_host_model (input wire logic scl_w, sda_w, output logic scl_low, sda_low, hang);
  localparam time HALF = 5000;
  initial {scl_low, sda_low, hang} = 3'h0;
  task automatic rel();
    scl_low = 0;
    for (int n = 0; scl_w !== 1'b1; n++) #100 if (n == 3000) hang = 1;
  endtask
  task automatic bit_x(input logic b, output logic s);
    #(HALF / 2) sda_low = !b;
    #(HALF / 2) rel();
    #(HALF / 2) s = sda_w;
    #(HALF / 2) scl_low = 1;
  endtask
  task automatic start();
    #(HALF / 2) sda_low = 0;
    #(HALF / 2) rel();
    #(HALF / 2) sda_low = 1;
    #(HALF / 2) scl_low = 1;
  endtask
  task automatic stop();
    #(HALF / 2) sda_low = 1;
    #(HALF / 2) rel();
    #(HALF / 2) sda_low = 0;
    #HALF;
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, s);
  endtask
endmodule

/* testbench/tws_slave_bench.sv */
// self-checking bench for the two-wire command slave
`timescale 1ns/10ps
module tws_slave_bench;
  logic             clk = 0, sys_rst = 1, proc_rdy = 0, ack;
  logic [7:0]       tx_byte = 8'h00, rd_b, txq[$];
  logic             scl_o, scl_oe, sda_o, sda_oe, ev_valid, scl_low, sda_low, hang, scl_w, sda_w;
  tws_pkg::tws_ev_t ev;
  logic [12:0]      evq[$];
  int               bad_count = 0, cmp_count = 0, scnt = 0, str_cyc = 3, od_bad = 0;
  always #50 clk = ~clk;
  assign scl_w = !(scl_low || scl_oe);
  assign sda_w = !(sda_low || sda_oe);
  tws_slave uut (.clk, .sys_rst, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o,
    .sda_oe, .ev, .ev_valid, .proc_rdy, .tx_byte);
  tws_host_model host (.scl_w, .sda_w, .scl_low, .sda_low, .hang);
  always @(posedge clk) begin
    if (ev_valid === 1'b1) evq.push_back({scl_oe, sda_oe, ev});
    if ((scl_oe && scl_o) || (sda_oe && sda_o)) od_bad++;
    #1 proc_rdy = 0;
    scnt = (scl_oe === 1'b1) ? scnt + 1 : 0;
    if (scnt == str_cyc) proc_rdy = 1;
    if (proc_rdy && ev.kind inside {tws_pkg::EV_ADDR_RD, tws_pkg::EV_RD_NEXT})
      tx_byte = txq.pop_front();
  end
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) bad_count++;
    if (seen !== exp) $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
  endtask
  task automatic exp_ev(input logic [2:0] k, input logic [7:0] d, input logic [1:0] oe);
    check(evq.pop_front(), {oe, k, d});
  endtask
  task automatic send(input logic [7:0] b, input logic a);
    host.wr(b, ack);
    check({12'h0, ack}, {12'h0, a});
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge hang) begin
    bad_count++;
    give_verdict();
  end
  task automatic t_foreign();
    host.start();
    send(8'hc2, 1'b0);
    send(8'hc0, 1'b0);
    host.stop();
    check(13'(evq.size()), 13'h0);
    $display("foreign done");
  endtask
  task automatic t_write();
    str_cyc = 1000;
    host.start();
    send(8'hc0, 1'b1);
    send(8'h03, 1'b1);
    send(8'ha5, 1'b1);
    host.stop();
    str_cyc = 3;
    exp_ev(tws_pkg::EV_ADDR_WR, 8'hc0, 2'h3);
    exp_ev(tws_pkg::EV_CMD, 8'h03, 2'h3);
    exp_ev(tws_pkg::EV_DATA, 8'ha5, 2'h3);
    exp_ev(tws_pkg::EV_STOP, 8'h00, 2'h0);
    $display("write done");
  endtask
  task automatic t_read();
    txq = '{8'h96, 8'h3c};
    host.start();
    send(8'hc0, 1'b1);
    send(8'h05, 1'b1);
    evq.delete();
    host.start();
    send(8'hc1, 1'b1);
    host.rd(1'b0, rd_b);
    check({5'h0, rd_b}, 13'h096);
    host.rd(1'b1, rd_b);
    check({5'h0, rd_b}, 13'h03c);
    host.stop();
    exp_ev(tws_pkg::EV_ADDR_RD, 8'hc1, 2'h3);
    exp_ev(tws_pkg::EV_RD_NEXT, 8'h00, 2'h2);
    check(13'(evq.size()), 13'h0);
    $display("read done");
  endtask
  task automatic t_cmd_only();
    host.start();
    send(8'hc0, 1'b1);
    send(8'h01, 1'b1);
    host.stop();
    exp_ev(tws_pkg::EV_ADDR_WR, 8'hc0, 2'h3);
    exp_ev(tws_pkg::EV_CMD, 8'h01, 2'h3);
    exp_ev(tws_pkg::EV_STOP, 8'h00, 2'h0);
    $display("command only done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 0;
    repeat (3) @(posedge clk);
    #1 check({11'h0, scl_oe, sda_oe}, 13'h0);
    t_foreign();
    t_write();
    t_read();
    t_cmd_only();
    check(13'(od_bad), 13'h0);
    give_verdict();
  end
endmodule
